// ==== hdl/lmv_top.v ====
// Eight-instance limit value monitor with a classic Wishbone register slave
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
`include "lmv_regs.vh"
module lmv_top #(
   parameter TICK_CYCLES = `LMV_TICK_CYCLES
) (
   input  wire         i_sys_clk,
   input  wire         i_rst,
   input  wire         i_wb_cyc,
   input  wire         i_wb_stb,
   input  wire         i_wb_we,
   input  wire [11:0]  i_wb_adr,
   input  wire [3:0]   i_wb_sel,
   input  wire [31:0]  i_wb_dat,
   output reg  [31:0]  o_wb_dat,
   output reg          o_wb_ack,
   input  wire [127:0] i_sensor_vals,
   input  wire [7:0]   i_binary_vals,
   input  wire [31:0]  i_ctrl_mv,
   input  wire [1:0]   i_ctrl_is_current,
   input  wire [63:0]  i_fbus_vals,
   input  wire [127:0] i_math_vals,
   input  wire [31:0]  i_mrs_vals,
   output wire [7:0]   o_relay,
   output reg  [3:0]   o_clean_start,
   output wire         o_irq
);
   // Picks the monitored value for one instance from its control word
   function [15:0] pick_value;
      input [15:0]  ctl;
      input [127:0] sens;
      input [7:0]   bin;
      input [31:0]  mv;
      input [1:0]   is_cur;
      input [63:0]  fbus;
      input [127:0] math;
      input [31:0]  mrs;
      reg   [2:0]   idx;
      reg   [15:0]  c_mv;
      begin
         idx  = ctl[`LMV_CTRL_IDX_LSB +: 3];
         c_mv = mv[idx[0]*16 +: 16];
         pick_value = 16'h0000;
         case (ctl[`LMV_CTRL_KIND_LSB +: 3])
            `LMV_SRC_SENSOR:   pick_value = sens[idx*16 +: 16];
            `LMV_SRC_BINARY:   pick_value = {15'h0000, bin[idx]};
            `LMV_SRC_CTRL: begin
               case (ctl[`LMV_CTRL_PART_LSB +: 2])
                  `LMV_PART_BIPOLAR:
                     pick_value = is_cur[idx[0]] ? c_mv : 16'h0000;
                  `LMV_PART_UNI_POS:
                     pick_value = c_mv[15] ? 16'h0000 : c_mv;
                  `LMV_PART_UNI_NEG:
                     pick_value = c_mv[15] ? (16'h0000 - c_mv) : 16'h0000;
                  default: pick_value = 16'h0000;
               endcase
            end
            `LMV_SRC_FBUS:     pick_value = fbus[idx[1:0]*16 +: 16];
            `LMV_SRC_MATH:     pick_value = math[idx*16 +: 16];
            `LMV_SRC_RANGESET: pick_value = mrs[idx[0]*16 +: 16];
            default:           pick_value = 16'h0000;
         endcase
      end
   endfunction

   // Bus handshake: address phase, then ack with data one cycle later
   reg         phase_reg;
   reg  [15:0] status_reg;
   reg  [15:0] irq_en_reg;
   wire        mem_busy;
   wire [15:0] bus_rdata;
   wire        req      = i_wb_cyc & i_wb_stb;
   wire        do_acc   = req & phase_reg & ~o_wb_ack;
   wire        is_cfg   = (i_wb_adr[11:8] == `LMV_CFG_PAGE) &&
                          (i_wb_adr[4:2] <= `LMV_FLD_LAST);
   wire [5:0]  bus_word = {i_wb_adr[7:5], i_wb_adr[4:2]};
   wire [15:0] wr_merge = {i_wb_sel[1] ? i_wb_dat[15:8] : bus_rdata[15:8],
                           i_wb_sel[0] ? i_wb_dat[7:0]  : bus_rdata[7:0]};
   wire        cfg_we   = do_acc & i_wb_we & is_cfg;
   wire        clr_we   = do_acc & i_wb_we & (i_wb_adr == `LMV_ADR_IRQ_CLR);
   wire [15:0] clr_mask = clr_we ? {i_wb_sel[1] ? i_wb_dat[15:8] : 8'h00,
                                    i_wb_sel[0] ? i_wb_dat[7:0]  : 8'h00} : 16'h0000;

   // Scan sequencer: one memory word per cycle, evaluation in slot six
   reg  [5:0]  scan_reg;
   reg  [5:0]  scan_d_reg;
   reg         scan_ok_reg;
   wire [15:0] scan_rdata;
   reg  [15:0] ctl_reg;
   reg  [15:0] lo_reg;
   reg  [15:0] hi_reg;
   reg  [15:0] hyst_reg;
   reg  [15:0] on_dly_reg;
   reg  [15:0] off_dly_reg;

   lmv_cfg_mem u_mem (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_we      (cfg_we),
      .i_waddr   (bus_word),
      .i_wdata   (wr_merge),
      .i_raddr_a (bus_word),
      .o_rdata_a (bus_rdata),
      .i_raddr_b (scan_reg),
      .o_rdata_b (scan_rdata),
      .o_busy    (mem_busy)
   );

   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         phase_reg <= 1'b0;
         o_wb_ack  <= 1'b0;
         o_wb_dat  <= 32'h00000000;
      end else begin
         // Hold off the bus until the memory has cleared itself
         phase_reg <= req & ~phase_reg & ~o_wb_ack & ~mem_busy;
         o_wb_ack  <= do_acc;
         if (do_acc) begin
            if (i_wb_we)
               o_wb_dat <= 32'h00000000;
            else if (is_cfg)
               o_wb_dat <= {16'h0000, bus_rdata};
            else if (i_wb_adr == `LMV_ADR_STATUS)
               o_wb_dat <= {16'h0000, status_reg};
            else if (i_wb_adr == `LMV_ADR_IRQ_EN)
               o_wb_dat <= {16'h0000, irq_en_reg};
            else if (i_wb_adr == `LMV_ADR_RELAY)
               o_wb_dat <= {24'h000000, o_relay};
            else
               o_wb_dat <= 32'h00000000;
         end
      end
   end

   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         scan_reg    <= 6'h00;
         scan_d_reg  <= 6'h00;
         scan_ok_reg <= 1'b0;
      end else begin
         scan_reg    <= scan_reg + 6'h01;
         scan_d_reg  <= scan_reg;
         scan_ok_reg <= ~mem_busy;
      end
   end

   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         ctl_reg     <= `LMV_CTRL_RESET;
         lo_reg      <= 16'h0000;
         hi_reg      <= 16'h0000;
         hyst_reg    <= 16'h0000;
         on_dly_reg  <= 16'h0000;
         off_dly_reg <= 16'h0000;
      end else begin
         case (scan_d_reg[2:0])
            `LMV_FLD_CTRL:    ctl_reg     <= scan_rdata;
            `LMV_FLD_LIM_LO:  lo_reg      <= scan_rdata;
            `LMV_FLD_LIM_HI:  hi_reg      <= scan_rdata;
            `LMV_FLD_HYST:    hyst_reg    <= scan_rdata;
            `LMV_FLD_ON_DLY:  on_dly_reg  <= scan_rdata;
            `LMV_FLD_OFF_DLY: off_dly_reg <= scan_rdata;
            default:          ctl_reg     <= ctl_reg;
         endcase
      end
   end

   // Time base for the delays; a tick is remembered until its slot is seen
   reg  [31:0] tick_cnt_reg;
   wire        tick = (tick_cnt_reg == TICK_CYCLES - 1);
   always @(posedge i_sys_clk) begin
      if (i_rst | tick)
         tick_cnt_reg <= 32'h00000000;
      else
         tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
   end

   wire        eval = scan_ok_reg & (scan_d_reg[2:0] == `LMV_FLD_EVAL);
   wire [2:0]  inst = scan_d_reg[5:3];
   reg  [7:0]  relay_reg;
   reg  [7:0]  tpend_reg;
   reg  [15:0] tmr_reg  [0:7];
   reg  [15:0] prev_reg [0:7];
   wire [15:0] value    = pick_value(ctl_reg, i_sensor_vals, i_binary_vals, i_ctrl_mv,
                                     i_ctrl_is_current, i_fbus_vals, i_math_vals, i_mrs_vals);
   wire        en       = ctl_reg[`LMV_CTRL_EN];
   wire [2:0]  mode     = ctl_reg[`LMV_CTRL_MODE_LSB +: 3];
   wire [2:0]  clean    = ctl_reg[`LMV_CTRL_CLEAN_LSB +: 3];

   reg signed [17:0] v;
   reg signed [17:0] d;
   reg signed [17:0] lo_up;
   reg signed [17:0] lo_dn;
   reg signed [17:0] hi_up;
   reg signed [17:0] hi_dn;
   reg               on_c;
   reg               off_c;

   always @* begin
      v     = {{2{value[15]}}, value};
      lo_up = {{2{lo_reg[15]}}, lo_reg} + {{2{hyst_reg[15]}}, hyst_reg};
      lo_dn = {{2{lo_reg[15]}}, lo_reg} - {{2{hyst_reg[15]}}, hyst_reg};
      hi_up = {{2{hi_reg[15]}}, hi_reg} + {{2{hyst_reg[15]}}, hyst_reg};
      hi_dn = {{2{hi_reg[15]}}, hi_reg} - {{2{hyst_reg[15]}}, hyst_reg};
      d     = v - {{2{prev_reg[inst][15]}}, prev_reg[inst]};
      if (d < 0)
         d = 18'sd0 - d;
      on_c  = 1'b0;
      off_c = 1'b0;
      case (mode)
         `LMV_MODE_ABOVE: begin
            on_c  = v > lo_up;
            off_c = v < lo_dn;
         end
         `LMV_MODE_BELOW: begin
            on_c  = v < lo_dn;
            off_c = v > lo_up;
         end
         `LMV_MODE_INSIDE: begin
            on_c  = (v > lo_up) && (v < hi_dn);
            off_c = (v < lo_dn) || (v > hi_up);
         end
         `LMV_MODE_OUTSIDE: begin
            on_c  = (v < lo_dn) || (v > hi_up);
            off_c = (v > lo_up) && (v < hi_dn);
         end
         // Rate is the step per scan pass, about 640 ns
         `LMV_MODE_RATE: begin
            on_c  = d > lo_up;
            off_c = d < lo_dn;
         end
         // Unknown codes behave as the reset mode
         default: begin
            on_c  = v > lo_up;
            off_c = v < lo_dn;
         end
      endcase
   end

   wire close_ev = eval & en & ~relay_reg[inst] & on_c & (tmr_reg[inst] >= on_dly_reg);
   wire open_ev  = eval & en & relay_reg[inst] & off_c & (tmr_reg[inst] >= off_dly_reg);

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_inst
         wire here = eval & (inst == g);
         always @(posedge i_sys_clk) begin
            if (i_rst) begin
               relay_reg[g] <= 1'b0;
               tpend_reg[g] <= 1'b0;
               tmr_reg[g]   <= 16'h0000;
               prev_reg[g]  <= 16'h0000;
            end else begin
               // A tick in the consuming cycle is kept for the next pass
               tpend_reg[g] <= tick | (tpend_reg[g] & ~here);
               if (here) begin
                  prev_reg[g] <= value;
                  if (!en) begin
                     relay_reg[g] <= 1'b0;
                     tmr_reg[g]   <= 16'h0000;
                  end else if (close_ev | open_ev) begin
                     relay_reg[g] <= close_ev;
                     tmr_reg[g]   <= 16'h0000;
                  end else if (relay_reg[g] ? off_c : on_c) begin
                     if (tpend_reg[g] && tmr_reg[g] != 16'hFFFF)
                        tmr_reg[g] <= tmr_reg[g] + 16'h0001;
                  end else begin
                     tmr_reg[g] <= 16'h0000;
                  end
               end
            end
         end
      end
   endgenerate

   assign o_relay = relay_reg;

   always @(posedge i_sys_clk) begin
      if (i_rst)
         o_clean_start <= 4'h0;
      else if (close_ev && clean != 3'h0 && clean <= 3'h4)
         o_clean_start <= 4'h1 << (clean - 3'h1);
      else
         o_clean_start <= 4'h0;
   end

   // Sticky events: low byte closed, high byte opened; set beats clear
   wire [15:0] set_mask = ({8'h00, {7'h00, close_ev} << inst}) |
                          ({{7'h00, open_ev} << inst, 8'h00});
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         status_reg <= `LMV_STATUS_RESET;
         irq_en_reg <= `LMV_IRQ_EN_RESET;
      end else begin
         status_reg <= (status_reg & ~clr_mask) | set_mask;
         if (do_acc && i_wb_we && i_wb_adr == `LMV_ADR_IRQ_EN)
            irq_en_reg <= {i_wb_sel[1] ? i_wb_dat[15:8] : irq_en_reg[15:8],
                           i_wb_sel[0] ? i_wb_dat[7:0]  : irq_en_reg[7:0]};
      end
   end

   assign o_irq = |(status_reg & irq_en_reg);
endmodule // lmv_top

// ==== hdl/lmv_regs.vh ====
// Register map, field layout and timing constants of the limit value monitor
`ifndef LMV_REGS_VH
`define LMV_REGS_VH

`define LMV_CLK_PERIOD_NS  10
`define LMV_TICK_NS        1000000
`define LMV_TICK_CYCLES    (`LMV_TICK_NS / `LMV_CLK_PERIOD_NS)

`define LMV_ADR_STATUS     12'h000
`define LMV_ADR_IRQ_EN     12'h004
`define LMV_ADR_IRQ_CLR    12'h008
`define LMV_ADR_RELAY      12'h00C
`define LMV_CFG_PAGE       4'h1

`define LMV_FLD_CTRL       3'h0
`define LMV_FLD_LIM_LO     3'h1
`define LMV_FLD_LIM_HI     3'h2
`define LMV_FLD_HYST       3'h3
`define LMV_FLD_ON_DLY     3'h4
`define LMV_FLD_OFF_DLY    3'h5
`define LMV_FLD_LAST       3'h5
`define LMV_FLD_EVAL       3'h6

`define LMV_CTRL_EN        0
`define LMV_CTRL_MODE_LSB  1
`define LMV_CTRL_CLEAN_LSB 4
`define LMV_CTRL_KIND_LSB  8
`define LMV_CTRL_IDX_LSB   11
`define LMV_CTRL_PART_LSB  14
`define LMV_CTRL_RESET     16'h0000

`define LMV_MODE_ABOVE     3'h0
`define LMV_MODE_BELOW     3'h1
`define LMV_MODE_INSIDE    3'h2
`define LMV_MODE_OUTSIDE   3'h3
`define LMV_MODE_RATE      3'h4

`define LMV_SRC_NONE       3'h0
`define LMV_SRC_SENSOR     3'h1
`define LMV_SRC_BINARY     3'h2
`define LMV_SRC_CTRL       3'h3
`define LMV_SRC_FBUS       3'h4
`define LMV_SRC_MATH       3'h5
`define LMV_SRC_RANGESET   3'h6

`define LMV_PART_BIPOLAR   2'h0
`define LMV_PART_UNI_POS   2'h1
`define LMV_PART_UNI_NEG   2'h2

`define LMV_STATUS_RESET   16'h0000
`define LMV_IRQ_EN_RESET   16'h0000

`endif

// ==== hdl/lmv_cfg_mem.v ====
// Configuration memory: 64 words, one write port, two registered read ports
`timescale 1ns/1ns
`include "lmv_regs.vh"
module lmv_cfg_mem (
   input  wire        i_sys_clk,
   input  wire        i_rst,
   input  wire        i_we,
   input  wire [5:0]  i_waddr,
   input  wire [15:0] i_wdata,
   input  wire [5:0]  i_raddr_a,
   output reg  [15:0] o_rdata_a,
   input  wire [5:0]  i_raddr_b,
   output reg  [15:0] o_rdata_b,
   output wire        o_busy
);
   reg [15:0] mem_reg [0:63];
   reg [5:0]  init_ptr_reg;
   reg        busy_reg;

   assign o_busy = busy_reg;

   // Walk all words after reset so every instance starts disabled
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         busy_reg     <= 1'b1;
         init_ptr_reg <= 6'h00;
      end else if (busy_reg) begin
         init_ptr_reg <= init_ptr_reg + 6'h01;
         if (init_ptr_reg == 6'h3F)
            busy_reg <= 1'b0;
      end
   end

   always @(posedge i_sys_clk) begin
      if (busy_reg)
         mem_reg[init_ptr_reg] <= `LMV_CTRL_RESET;
      else if (i_we)
         mem_reg[i_waddr] <= i_wdata;
      o_rdata_a <= mem_reg[i_raddr_a];
      o_rdata_b <= mem_reg[i_raddr_b];
   end
endmodule // lmv_cfg_mem

// ==== tb/lmv_props.sv ====
// Concurrent checks on the limit value monitor top-level ports
`timescale 1ns/1ns
module lmv_props #(
   parameter TICK_CYCLES = 20
) (
   input wire        i_sys_clk,
   input wire        i_rst,
   input wire        i_wb_cyc,
   input wire        i_wb_stb,
   input wire [31:0] o_wb_dat,
   input wire        o_wb_ack,
   input wire [7:0]  o_relay,
   input wire [3:0]  o_clean_start,
   input wire        o_irq
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   // Config memory init can delay the first answer
   sequence s_req_rise;
      $rose(i_wb_cyc && i_wb_stb);
   endsequence
   sequence s_ack_soon;
      ##[1:80] o_wb_ack;
   endsequence
   a_ack_bounded: assert property (s_req_rise |-> s_ack_soon)
      else $error("bus request not answered");
   a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack longer than one cycle");
   a_ack_has_req: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
      else $error("ack without request");
   a_dat_upper: assert property (o_wb_ack |-> o_wb_dat[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   a_reset_quiet: assert property ($past(i_rst) |->
      (o_relay == 8'h00 && o_clean_start == 4'h0 && !o_irq && !o_wb_ack))
      else $error("outputs active after reset");
   a_clean_onehot: assert property ($onehot0(o_clean_start))
      else $error("two cleaning starts at once");
   // Clean start goes out with the closing edge
   a_clean_closes: assert property (o_clean_start != 4'h0 |->
      $countones(o_relay) == $countones($past(o_relay)) + 1)
      else $error("cleaning start without relay closing");
   a_one_change: assert property ($countones(o_relay ^ $past(o_relay)) <= 1)
      else $error("two relays switched in one cycle");
endmodule // lmv_props

bind lmv_top lmv_props #(.TICK_CYCLES(TICK_CYCLES)) i_lmv_props (
   .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
   .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_relay(o_relay),
   .o_clean_start(o_clean_start), .o_irq(o_irq));

// ==== tb/lmv_src_model.sv ====
// Process value sources: one level fanned out to every source slot
`timescale 1ns/1ns
module lmv_src_model (
   input  wire [15:0]  i_level,
   output wire [127:0] o_sensor_vals,
   output wire [7:0]   o_binary_vals,
   output wire [31:0]  o_ctrl_mv,
   output wire [1:0]   o_ctrl_is_current,
   output wire [63:0]  o_fbus_vals,
   output wire [127:0] o_math_vals,
   output wire [31:0]  o_mrs_vals
);
   assign o_sensor_vals = {8{i_level}};
   assign o_binary_vals = {8{|i_level}};
   assign o_fbus_vals   = {4{i_level}};
   assign o_mrs_vals    = {2{i_level}};
   assign o_math_vals   = {8{i_level}};
   assign o_ctrl_mv         = {2{i_level}};
   assign o_ctrl_is_current = 2'b01;
endmodule // lmv_src_model

// ==== tb/tb.sv ====
// Register-level testbench of the limit value monitor
`timescale 1ns/1ns
`include "lmv_regs.vh"
`define CHK(nm, e, g) begin cmp_count = cmp_count + 1; if ((g) !== (e)) begin \
   errors = errors + 1; $display("BAD %0s exp %0h got %0h", nm, e, g); end end
module tb;
   // Tick must outlast one 64-cycle scan pass or ticks merge
   localparam TICK = 100;
   reg          clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   reg  [11:0]  adr = 12'h000;
   reg  [3:0]   sel = 4'h0;
   reg  [31:0]  wdat = 32'h00000000;
   reg  [15:0]  level = 16'h0000;
   reg  [31:0]  q;
   reg  [7:0]   seen = 8'h00;
   reg  [3:0]   clean_seen = 4'h0;
   wire [31:0]  rdat, mv, mrs;
   wire [127:0] sens, math;
   wire [63:0]  fbus;
   wire [7:0]   bin, relay;
   wire [3:0]   clean;
   wire [1:0]   iscur;
   wire         ack, irq;
   integer      errors = 0, cmp_count = 0, cycles = 0, n;
   always #5 clk = ~clk;
   lmv_src_model i_lmv_src_model (.i_level(level), .o_sensor_vals(sens), .o_binary_vals(bin),
      .o_ctrl_mv(mv), .o_ctrl_is_current(iscur), .o_fbus_vals(fbus), .o_math_vals(math),
      .o_mrs_vals(mrs));
   lmv_top #(.TICK_CYCLES(TICK)) i_lmv_top (.i_sys_clk(clk), .i_rst(rst), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
      .o_wb_dat(rdat), .o_wb_ack(ack), .i_sensor_vals(sens), .i_binary_vals(bin),
      .i_ctrl_mv(mv), .i_ctrl_is_current(iscur), .i_fbus_vals(fbus), .i_math_vals(math),
      .i_mrs_vals(mrs), .o_relay(relay), .o_clean_start(clean), .o_irq(irq));
   always @(posedge clk) begin
      seen <= seen | relay;
      clean_seen <= clean_seen | clean;
      cycles = cycles + 1;
      if (cycles == 40000) begin
         errors = errors + 1;
         summarize;
      end
   end
   task summarize;
      begin
         $display("Checks %0d mismatches %0d", cmp_count, errors);
         if (errors == 0 && cmp_count > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask
   // Held until ack is seen high at a rising edge
   task wb(input w, input [11:0] a, input [15:0] d);
      integer k;
      begin
         @(posedge clk);
         cyc <= 1'b1;
         stb <= 1'b1;
         we <= w;
         adr <= a;
         sel <= 4'h3;
         wdat <= {16'h0000, d};
         k = 0;
         @(posedge clk);
         while (ack !== 1'b1 && k < 500) begin
            @(posedge clk);
            k = k + 1;
         end
         if (k >= 500)
            errors = errors + 1;
         q = rdat;
         cyc <= 1'b0;
         stb <= 1'b0;
      end
   endtask
   task rd(input [63:0] nm, input [11:0] a, input [15:0] e);
      begin wb(1'b0, a, 16'h0000); `CHK(nm, {16'h0000, e}, q) end
   endtask
   function [11:0] ca(input [2:0] i, input [2:0] f);
      ca = 12'h100 + {4'h0, i, 5'h00} + {7'h00, f, 2'b00};
   endfunction
   task cfg(input [2:0] i, input [2:0] md, input [2:0] cl, input [2:0] src, input [2:0] ix,
            input [1:0] pt, input en, input [15:0] lo, input [15:0] hi, input [15:0] h);
      begin
         wb(1'b1, ca(i, `LMV_FLD_LIM_LO), lo);
         wb(1'b1, ca(i, `LMV_FLD_LIM_HI), hi);
         wb(1'b1, ca(i, `LMV_FLD_HYST), h);
         wb(1'b1, ca(i, `LMV_FLD_CTRL), {pt, ix, src, 1'b0, cl, md, en});
      end
   endtask
   task wbit(input integer b, input v);
      begin n = 0; while (relay[b] !== v && n < 2000) begin @(negedge clk); n = n + 1; end end
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd("ctrl0", ca(0, `LMV_FLD_CTRL), `LMV_CTRL_RESET);
      rd("ctrl7", ca(7, `LMV_FLD_CTRL), `LMV_CTRL_RESET);
      rd("irq_en", `LMV_ADR_IRQ_EN, `LMV_IRQ_EN_RESET);
      rd("unmapped", 12'hFFC, 16'h0000);
      wb(1'b1, `LMV_ADR_STATUS, 16'hFFFF);
      rd("status", `LMV_ADR_STATUS, `LMV_STATUS_RESET);
      wb(1'b1, ca(0, `LMV_FLD_ON_DLY), 16'h0004);
      wb(1'b1, ca(0, `LMV_FLD_OFF_DLY), 16'h0001);
      cfg(0, `LMV_MODE_ABOVE, 3'h1, `LMV_SRC_SENSOR, 3'h0, 2'h0, 1'b1, 16'd100, 16'd0, 16'd10);
      // Short excursion must not survive the on-delay
      @(posedge clk) level <= 16'd115;
      repeat (30) @(posedge clk);
      level <= 16'd50;
      repeat (300) @(negedge clk);
      `CHK("glitch", 1'b0, relay[0])
      @(posedge clk) level <= 16'd115;
      wbit(0, 1'b1);
      // Delay counts whole ticks seen at evaluations, so one tick of slack
      `CHK("on_dly", 1'b1, n >= 3 * TICK && n < 6 * TICK)
      repeat (2) @(negedge clk);
      `CHK("clean", 4'h1, clean_seen)
      rd("st_close", `LMV_ADR_STATUS, 16'h0001);
      rd("relay_rd", `LMV_ADR_RELAY, 16'h0001);
      `CHK("irq_off", 1'b0, irq)
      wb(1'b1, `LMV_ADR_IRQ_EN, 16'h0001);
      `CHK("irq_on", 1'b1, irq)
      rd("irq_en", `LMV_ADR_IRQ_EN, 16'h0001);
      wb(1'b1, `LMV_ADR_IRQ_CLR, 16'h0001);
      `CHK("irq_clr", 1'b0, irq)
      @(posedge clk) level <= 16'd95;
      repeat (300) @(negedge clk);
      `CHK("hyst", 1'b1, relay[0])
      @(posedge clk) level <= 16'd80;
      wbit(0, 1'b0);
      `CHK("off_dly", 1'b1, n >= TICK / 2 && n < 3 * TICK)
      rd("st_open", `LMV_ADR_STATUS, 16'h0100);
      `CHK("irq_mask", 1'b0, irq)
      // Every mode and every source kind but binary and none on separate instances
      @(posedge clk) level <= 16'd0;
      @(negedge clk);
      seen = 8'h00;
      clean_seen = 4'h0;
      wb(1'b1, ca(0, `LMV_FLD_ON_DLY), 16'h0000);
      cfg(0, `LMV_MODE_RATE, 3'h0, `LMV_SRC_SENSOR, 3'h0, 2'h0, 1'b1, 16'd50, 16'd0, 16'd5);
      cfg(1, `LMV_MODE_BELOW, 3'h1, `LMV_SRC_SENSOR, 3'h1, 2'h0, 1'b1, 16'd300, 16'd0, 16'd10);
      cfg(2, `LMV_MODE_INSIDE, 3'h2, `LMV_SRC_MATH, 3'h0, 2'h0, 1'b1, 16'd100, 16'd300, 16'd10);
      cfg(3, `LMV_MODE_OUTSIDE, 3'h3, `LMV_SRC_FBUS, 3'h2, 2'h0, 1'b1, 16'd100, 16'd150, 16'd10);
      cfg(4, `LMV_MODE_ABOVE, 3'h4, `LMV_SRC_CTRL, 3'h0, `LMV_PART_BIPOLAR, 1'b1, 16'd100, 16'd0,
          16'd10);
      cfg(5, `LMV_MODE_ABOVE, 3'h0, `LMV_SRC_RANGESET, 3'h1, 2'h0, 1'b1, 16'd100, 16'd0, 16'd10);
      cfg(6, `LMV_MODE_ABOVE, 3'h0, `LMV_SRC_CTRL, 3'h1, `LMV_PART_BIPOLAR, 1'b1, 16'd100, 16'd0,
          16'd10);
      cfg(7, `LMV_MODE_ABOVE, 3'h0, `LMV_SRC_SENSOR, 3'h0, 2'h0, 1'b0, 16'd100, 16'd0, 16'd10);
      @(posedge clk) level <= 16'd200;
      repeat (400) @(negedge clk);
      `CHK("closed", 8'h3F, seen)
      `CHK("cleans", 4'hF, clean_seen)
      @(posedge clk) level <= 16'd80;
      repeat (300) @(negedge clk);
      `CHK("range_off", 2'b01, relay[2:1])
      // Signed controller parts, binary input and no source at all
      @(posedge clk) level <= 16'hFF38;
      cfg(4, `LMV_MODE_ABOVE, 3'h0, `LMV_SRC_CTRL, 3'h0, `LMV_PART_UNI_NEG, 1'b1, 16'd100, 16'd0,
          16'd10);
      cfg(5, `LMV_MODE_ABOVE, 3'h0, `LMV_SRC_BINARY, 3'h0, 2'h0, 1'b1, 16'd0, 16'd0, 16'd0);
      cfg(6, `LMV_MODE_ABOVE, 3'h0, `LMV_SRC_CTRL, 3'h1, `LMV_PART_UNI_POS, 1'b1, 16'hFFF6, 16'd0,
          16'd0);
      cfg(7, `LMV_MODE_ABOVE, 3'h0, `LMV_SRC_NONE, 3'h0, 2'h0, 1'b1, 16'hFFF6, 16'd0, 16'd0);
      repeat (200) @(negedge clk);
      `CHK("signed_src", 4'hF, relay[7:4])
      @(posedge clk) rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      `CHK("rst_relay", 8'h00, relay)
      rd("ctrl1", ca(1, `LMV_FLD_CTRL), `LMV_CTRL_RESET);
      summarize;
   end
endmodule // tb
